// ### wesb_pkg.sv
package wesb_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] WESB_IDX_GPIO_STS = 8'h08;
  localparam logic [7:0] WESB_IDX_PERI_STS = 8'h09;
  localparam logic [7:0] WESB_IDX_GPIO_EN = 8'h10;
  localparam logic [7:0] WESB_IDX_PERI_EN = 8'h11;
  localparam logic [7:0] WESB_IDX_CTRL = 8'h12;
  localparam logic [7:0] WESB_IDX_IRQ_STS = 8'h13;
  localparam logic [7:0] WESB_IDX_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WESB_GPIO_STS_RST = 8'h00;
  localparam logic [7:0] WESB_PERI_STS_RST = 8'h01;
  localparam logic [7:0] WESB_EN_RST = 8'h00;
  localparam logic [1:0] WESB_CTRL_RST = 2'h0;
  localparam logic [1:0] WESB_IRQ_RST = 2'h0;
  localparam logic [31:0] WESB_RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned WESB_CTRL_MASTER_BIT = 0;
  localparam int unsigned WESB_CTRL_ACTIVATE_BIT = 1;
  localparam int unsigned WESB_PERI_PRINTER_BIT = 0;
  localparam int unsigned WESB_PERI_MIDI_BIT = 1;
  localparam int unsigned WESB_PERI_SERIAL_BIT = 2;
  localparam int unsigned WESB_PERI_FLOPPY_BIT = 3;
  localparam int unsigned WESB_PERI_POINTER_BIT = 4;
  localparam int unsigned WESB_PERI_KEYS_BIT = 5;
  localparam int unsigned WESB_PERI_WATCHDOG_BIT = 6;
  localparam int unsigned WESB_PERI_SMBUS_BIT = 7;
  localparam int unsigned WESB_IRQ_GPIO_BIT = 0;
  localparam int unsigned WESB_IRQ_PERI_BIT = 1;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned WESB_STS_W = 8;
  localparam int unsigned WESB_IRQ_W = 2;

endpackage

// ### wesb_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser with rising-edge detect on the second stage
module wesb_sync_edge
  import wesb_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // meta_reg is read by sync_reg only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;

endmodule

`default_nettype wire

// ### wesb_w1c_bank.sv
`timescale 1ns/1ps
`default_nettype none

// sticky bank, write-one-to-clear; a set in the clear cycle wins
module wesb_w1c_bank
  import wesb_pkg::*;
#(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] q
);

  // only the standby reset reaches this flop; other resets act only on the peripheral bank, via its set_in
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else if (clk_en) begin
      q <= (q & ~clr_in) | set_in;
    end
  end

endmodule

`default_nettype wire

// ### wesb_top.sv
`timescale 1ns/1ps
`default_nettype none

module wesb_top
  import wesb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic gpio_five_zero,
  input wire logic gpio_five_one,
  input wire logic gpio_five_two,
  input wire logic gpio_five_three,
  input wire logic gpio_five_four,
  input wire logic gpio_five_five,
  input wire logic gpio_five_six,
  input wire logic gpio_five_seven,
  input wire logic printer_acknowledge_in,
  input wire logic midi_uart_irq_req,
  input wire logic serial_port_irq_req,
  input wire logic floppy_irq_req,
  input wire logic pointer_irq_req,
  input wire logic keys_irq_req,
  input wire logic watchdog_irq_req,
  input wire logic smbus_irq_req,
  input wire logic main_power_reset,
  input wire logic soft_reset,
  input wire logic hard_reset,
  output logic [7:0] gpio_wake_status_c,
  output logic [7:0] peripheral_event_status,
  output logic wake_output_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // source synchronisation
  // ----------------------------------------------------------------
  logic [7:0] gpio_raw;
  logic [7:0] gpio_lvl;
  logic [7:0] gpio_rise;
  logic [7:0] peri_raw;
  logic [7:0] peri_lvl;
  logic [7:0] peri_rise;

  assign gpio_raw = {gpio_five_seven, gpio_five_six, gpio_five_five,
                     gpio_five_four, gpio_five_three, gpio_five_two,
                     gpio_five_one, gpio_five_zero};

  // bit order fixes the flag positions of the peripheral register
  assign peri_raw = {smbus_irq_req, watchdog_irq_req, keys_irq_req,
                     pointer_irq_req, floppy_irq_req, serial_port_irq_req,
                     midi_uart_irq_req, printer_acknowledge_in};

  wesb_sync_edge #(.W(WESB_STS_W)) u_gpio_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .async_in(gpio_raw),
    .level(gpio_lvl),
    .rise(gpio_rise)
  );

  wesb_sync_edge #(.W(WESB_STS_W)) u_peri_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .async_in(peri_raw),
    .level(peri_lvl),
    .rise(peri_rise)
  );

  // ----------------------------------------------------------------
  // bus slave: one wait state so a read always sees earlier writes
  // ----------------------------------------------------------------
  logic pend_reg;
  logic pend_write_reg;
  logic pend_mapped_reg;
  logic [7:0] pend_idx_reg;
  logic addr_take;
  logic addr_mapped;
  logic wr_stage;
  logic rd_stage;

  assign addr_take = hsel && htrans[1] && hready && clk_en;
  assign addr_mapped = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
  assign wr_stage = pend_reg && pend_write_reg && pend_mapped_reg && clk_en;
  assign rd_stage = pend_reg && !pend_write_reg && clk_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      pend_write_reg <= 1'b0;
      pend_mapped_reg <= 1'b0;
      pend_idx_reg <= 8'h00;
    end else if (clk_en) begin
      pend_reg <= addr_take;
      if (addr_take) begin
        pend_write_reg <= hwrite;
        pend_mapped_reg <= addr_mapped;
        pend_idx_reg <= haddr[9:2];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= !addr_take;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and enable registers
  // ----------------------------------------------------------------
  logic [7:0] gpio_en_reg;
  logic [7:0] peri_en_reg;
  logic [1:0] ctrl_reg;
  logic [1:0] irq_mask_reg;
  logic master_en;
  logic activate;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_en_reg <= WESB_EN_RST;
      peri_en_reg <= WESB_EN_RST;
      ctrl_reg <= WESB_CTRL_RST;
      irq_mask_reg <= WESB_IRQ_RST;
    end else if (wr_stage) begin
      if (pend_idx_reg == WESB_IDX_GPIO_EN) begin
        gpio_en_reg <= hwdata[7:0];
      end
      if (pend_idx_reg == WESB_IDX_PERI_EN) begin
        peri_en_reg <= hwdata[7:0];
      end
      if (pend_idx_reg == WESB_IDX_CTRL) begin
        ctrl_reg <= hwdata[1:0];
      end
      if (pend_idx_reg == WESB_IDX_IRQ_MASK) begin
        irq_mask_reg <= hwdata[1:0];
      end
    end
  end

  assign master_en = ctrl_reg[WESB_CTRL_MASTER_BIT];
  assign activate = ctrl_reg[WESB_CTRL_ACTIVATE_BIT];

  // ----------------------------------------------------------------
  // printer source
  // ----------------------------------------------------------------
  logic printer_port_irq_flag_src;
  logic printer_port_irq_flag_prev_reg;
  logic printer_port_irq_flag_rise;
  logic any_reset;

  assign printer_port_irq_flag_src = activate ? peri_lvl[WESB_PERI_PRINTER_BIT] : 1'b1;
  assign any_reset = main_power_reset || soft_reset || hard_reset;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      printer_port_irq_flag_prev_reg <= 1'b1;
    end else if (clk_en) begin
      printer_port_irq_flag_prev_reg <= printer_port_irq_flag_src;
    end
  end

  assign printer_port_irq_flag_rise = printer_port_irq_flag_src && !printer_port_irq_flag_prev_reg;

  // ----------------------------------------------------------------
  // status banks
  // ----------------------------------------------------------------
  logic [7:0] gpio_set;
  logic [7:0] gpio_clr;
  logic [7:0] peri_set;
  logic [7:0] peri_clr;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [1:0] irq_sts;

  // enables play no part in setting status
  assign gpio_set = gpio_rise;
  assign gpio_clr = (wr_stage && pend_idx_reg == WESB_IDX_GPIO_STS) ?
                    hwdata[7:0] : 8'h00;

  // held source and non-standby resets keep bit 0 set while active
  assign peri_set[WESB_PERI_PRINTER_BIT] = printer_port_irq_flag_rise || !activate ||
                                           any_reset;
  assign peri_set[7:1] = peri_rise[7:1];
  assign peri_clr = (wr_stage && pend_idx_reg == WESB_IDX_PERI_STS) ?
                    hwdata[7:0] : 8'h00;

  wesb_w1c_bank #(.W(WESB_STS_W), .RST(WESB_GPIO_STS_RST)) u_gpio_sts (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .set_in(gpio_set),
    .clr_in(gpio_clr),
    .q(gpio_wake_status_c)
  );

  wesb_w1c_bank #(.W(WESB_STS_W), .RST(WESB_PERI_STS_RST)) u_peri_sts (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .set_in(peri_set),
    .clr_in(peri_clr),
    .q(peripheral_event_status)
  );

  assign irq_set[WESB_IRQ_GPIO_BIT] = |gpio_set;
  assign irq_set[WESB_IRQ_PERI_BIT] = |peri_set[7:1] || printer_port_irq_flag_rise;
  assign irq_clr = (wr_stage && pend_idx_reg == WESB_IDX_IRQ_STS) ?
                   hwdata[1:0] : 2'h0;

  wesb_w1c_bank #(.W(WESB_IRQ_W), .RST(WESB_IRQ_RST)) u_irq_sts (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .set_in(irq_set),
    .clr_in(irq_clr),
    .q(irq_sts)
  );

  // ----------------------------------------------------------------
  // wake and interrupt outputs
  // ----------------------------------------------------------------
  logic wake_cond;

  assign wake_cond = master_en &&
                     (|(gpio_wake_status_c & gpio_en_reg) ||
                      |(peripheral_event_status & peri_en_reg));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_output_n <= 1'b1;
      irq <= 1'b0;
    end else if (clk_en) begin
      wake_output_n <= !wake_cond;
      irq <= |(irq_sts & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_value;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (pend_mapped_reg) begin
      case (pend_idx_reg)
        WESB_IDX_GPIO_STS: rd_value = {24'h00_0000, gpio_wake_status_c};
        WESB_IDX_PERI_STS: rd_value = {24'h00_0000, peripheral_event_status};
        WESB_IDX_GPIO_EN: rd_value = {24'h00_0000, gpio_en_reg};
        WESB_IDX_PERI_EN: rd_value = {24'h00_0000, peri_en_reg};
        WESB_IDX_CTRL: rd_value = {30'h0000_0000, ctrl_reg};
        WESB_IDX_IRQ_STS: rd_value = {30'h0000_0000, irq_sts};
        WESB_IDX_IRQ_MASK: rd_value = {30'h0000_0000, irq_mask_reg};
        default: rd_value = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= WESB_RDATA_RST;
    end else if (rd_stage) begin
      hrdata <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_addr_phase;
    hsel && htrans[1] && hready && clk_en;
  endsequence

  sequence s_wait_then_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_wait_state: assert property (
    s_addr_phase ##1 clk_en |-> s_wait_then_ready)
    else $error("bus answer not after exactly one wait state");

  a_gpio_event_sets: assert property (
    clk_en && gpio_rise != 8'h00 |=>
    (gpio_wake_status_c & $past(gpio_rise)) == $past(gpio_rise))
    else $error("gpio event did not set its status bit");

  a_gpio_bits_sticky: assert property (
    clk_en |=> ($past(gpio_wake_status_c) & ~$past(gpio_clr) &
                ~gpio_wake_status_c) == 8'h00)
    else $error("gpio status bit dropped without a clear");

  a_gpio_w1c_clear: assert property (
    clk_en && gpio_clr != 8'h00 |=>
    (gpio_wake_status_c & $past(gpio_clr) & ~$past(gpio_set)) == 8'h00)
    else $error("gpio write of one did not clear");

  a_set_beats_clear: assert property (
    clk_en && (gpio_set & gpio_clr) != 8'h00 |=>
    (gpio_wake_status_c & $past(gpio_set & gpio_clr)) ==
    $past(gpio_set & gpio_clr))
    else $error("clear won over a coincident event");

  a_peri_event_sets: assert property (
    clk_en && peri_rise[7:1] != 7'h00 |=>
    (peripheral_event_status[7:1] & $past(peri_rise[7:1])) ==
    $past(peri_rise[7:1]))
    else $error("peripheral event did not set its status bit");

  a_peri_w1c_clear: assert property (
    clk_en && peri_clr[7:1] != 7'h00 |=>
    (peripheral_event_status[7:1] & $past(peri_clr[7:1]) &
     ~$past(peri_set[7:1])) == 7'h00)
    else $error("peripheral write of one did not clear");

  a_printer_reset_force: assert property (
    clk_en && any_reset |=> peripheral_event_status[0])
    else $error("printer flag not forced by reset");

  a_printer_idle_high: assert property (
    clk_en && !activate [*2] |=> peripheral_event_status[0])
    else $error("printer flag clear while port inactive");

  a_printer_ack_rise: assert property (
    clk_en && activate && printer_port_irq_flag_rise |=> peripheral_event_status[0])
    else $error("printer acknowledge edge not latched");

  a_wake_gating: assert property (
    clk_en |=> wake_output_n == !$past(wake_cond))
    else $error("wake output does not match enabled status");

endmodule

`default_nettype wire

// ### test_wake_event_status_bank.sv
`timescale 1ns/1ps
`default_nettype none

module test_wake_event_status_bank
  import wesb_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] gp = 8'h0;
  logic [7:0] pr = 8'h0;
  logic [2:0] other_rst = 3'h0;
  logic [7:0] gpio_wake_status_c;
  logic [7:0] peripheral_event_status;
  logic wake_output_n;
  logic irq;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] acc;

  always #2 hclk = ~hclk;

  wesb_top wesb_top_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata),
    .gpio_five_zero(gp[0]), .gpio_five_one(gp[1]), .gpio_five_two(gp[2]),
    .gpio_five_three(gp[3]), .gpio_five_four(gp[4]),
    .gpio_five_five(gp[5]), .gpio_five_six(gp[6]),
    .gpio_five_seven(gp[7]), .printer_acknowledge_in(pr[0]),
    .midi_uart_irq_req(pr[1]), .serial_port_irq_req(pr[2]),
    .floppy_irq_req(pr[3]), .pointer_irq_req(pr[4]),
    .keys_irq_req(pr[5]), .watchdog_irq_req(pr[6]),
    .smbus_irq_req(pr[7]), .main_power_reset(other_rst[0]),
    .soft_reset(other_rst[1]), .hard_reset(other_rst[2]),
    .gpio_wake_status_c(gpio_wake_status_c),
    .peripheral_event_status(peripheral_event_status),
    .wake_output_n(wake_output_n), .irq(irq)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus access
  // ----------------------------------------------------------------
  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  // waits for hready at a rising edge; a hung slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(hresp, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, adr(idx), d, r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, adr(idx), 32'h0, r);
    check(r, exp);
  endtask

  // a rising edge on the chosen sources, held past the sync latency
  task automatic ev(input logic [7:0] g, input logic [7:0] p);
    gp <= g;
    pr <= p;
    repeat (5) @(posedge hclk);
    gp <= 8'h0;
    pr <= 8'h0;
    repeat (3) @(posedge hclk);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(WESB_IDX_GPIO_STS, 32'h0);
    rd(WESB_IDX_PERI_STS, 32'h1);
    check(wake_output_n, 32'h1);
    $display("test reset values done");

    acc = 8'h0;
    for (int i = 0; i < 8; i++) begin
      ev(8'h1 << i, 8'h0);
      acc = acc | (8'h1 << i);
      rd(WESB_IDX_GPIO_STS, {24'h0, acc});
      check(gpio_wake_status_c, {24'h0, acc});
    end
    wr(WESB_IDX_GPIO_STS, 32'h0);
    rd(WESB_IDX_GPIO_STS, 32'hff);
    wr(WESB_IDX_GPIO_STS, 32'h0f);
    rd(WESB_IDX_GPIO_STS, 32'hf0);
    $display("test gpio status done");

    wr(WESB_IDX_CTRL, 32'h2);
    wr(WESB_IDX_PERI_STS, 32'hff);
    rd(WESB_IDX_PERI_STS, 32'h0);
    acc = 8'h0;
    for (int i = 0; i < 8; i++) begin
      ev(8'h0, 8'h1 << i);
      acc = acc | (8'h1 << i);
      rd(WESB_IDX_PERI_STS, {24'h0, acc});
      check(peripheral_event_status, {24'h0, acc});
    end
    wr(WESB_IDX_PERI_STS, 32'haa);
    rd(WESB_IDX_PERI_STS, 32'h55);
    wr(WESB_IDX_PERI_STS, 32'h0);
    rd(WESB_IDX_PERI_STS, 32'h55);
    $display("test peripheral status done");

    // only bit 0 is cleared, so the other flags show that they survive
    for (int k = 0; k < 3; k++) begin
      wr(WESB_IDX_PERI_STS, 32'h1);
      other_rst <= 3'h1 << k;
      repeat (2) @(posedge hclk);
      other_rst <= 3'h0;
      rd(WESB_IDX_PERI_STS, 32'h55);
      rd(WESB_IDX_GPIO_STS, 32'hf0);
    end
    wr(WESB_IDX_CTRL, 32'h0);
    wr(WESB_IDX_PERI_STS, 32'h1);
    rd(WESB_IDX_PERI_STS, 32'h55);
    $display("test other resets done");

    // bit 7 of gpio status is still set from the earlier events
    wr(WESB_IDX_GPIO_EN, 32'h80);
    rd(WESB_IDX_GPIO_EN, 32'h80);
    repeat (2) @(posedge hclk);
    check(wake_output_n, 32'h1);
    wr(WESB_IDX_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    check(wake_output_n, 32'h0);
    wr(WESB_IDX_GPIO_STS, 32'h80);
    repeat (2) @(posedge hclk);
    check(wake_output_n, 32'h1);
    $display("test wake output done");

    wr(WESB_IDX_IRQ_STS, 32'h3);
    rd(WESB_IDX_IRQ_STS, 32'h0);
    wr(WESB_IDX_IRQ_MASK, 32'h1);
    check(irq, 32'h0);
    ev(8'h1, 8'h0);
    rd(WESB_IDX_IRQ_STS, 32'h1);
    check(irq, 32'h1);
    wr(WESB_IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    check(irq, 32'h0);
    wr(WESB_IDX_IRQ_STS, 32'h1);
    rd(WESB_IDX_IRQ_STS, 32'h0);
    $display("test interrupt done");

    // a frozen block must not see the pin until the enable returns
    clk_en <= 1'b0;
    gp <= 8'h04;
    repeat (5) @(posedge hclk);
    check(gpio_wake_status_c, 32'h71);
    clk_en <= 1'b1;
    repeat (5) @(posedge hclk);
    check(gpio_wake_status_c, 32'h75);
    $display("test clock enable done");

    // bit 1 rises so that its set lands in the clear cycle of the write
    gp <= 8'h06;
    @(posedge hclk);
    wr(WESB_IDX_GPIO_STS, 32'h02);
    rd(WESB_IDX_GPIO_STS, 32'h77);
    check(gpio_wake_status_c, 32'h77);
    gp <= 8'h0;
    $display("test set beats clear done");

    wr(8'h0f, 32'hffff_ffff);
    rd(8'h0f, 32'h0);
    $display("test unmapped done");

    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(gpio_wake_status_c, 32'h0);
    check(peripheral_event_status, 32'h1);
    rd(WESB_IDX_GPIO_STS, 32'h0);
    rd(WESB_IDX_PERI_STS, 32'h1);
    $display("test standby reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
